// ### hdl/tap_params.svh
// constants of the boundary-scan test access port
// What this block does
// [RQ1] full four-wire test port with the standard sixteen-state controller
// [RQ2] boundary instructions fall back to bypass while configuration runs
// [RQ3] instruction register is exactly ten bits between serial in and out
// [RQ4] sample/preload captures pins, loads a pattern, normal operation continues
// [RQ5] external test drives pins from update stage and captures inputs
// [RQ6] bypass puts one bit between serial in and out, captured as zero
// [RQ7] signature register is 32 bits: 7 from user, 25 fixed
// [RQ8] identification instruction puts the identification register in the path
// [RQ9] id word: 4-bit version, 16-bit part, 11-bit maker, one bit
// [RQ10] id least significant bit is one and leaves first
// [RQ11] boundary chain length is 690, 798, 1050, 1308 or 1446 cells
// [RQ12] configuration instructions stream serial data to the configuration loader
// [RQ13] open-drain outputs only drive low or release, never drive high
// [RQ14] all pins undriven until operating conditions are reached
// [RQ15] opcodes are parameters; unknown opcodes select bypass
// [RQ16] reset loads identification; serial out released outside shift states
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define TAP_IR_LEN        10
`define TAP_IR_CAPTURE    10'h001
`define TAP_BSR_LEN_DEF   690
`define TAP_OP_EXTEST     10'h000
`define TAP_OP_SAMPLE     10'h005
`define TAP_OP_IDCODE     10'h006
`define TAP_OP_USERCODE   10'h007
`define TAP_OP_CFG_LOAD   10'h002
`define TAP_OP_CFG_START  10'h003
`define TAP_OP_BYPASS     10'h3FF
// identity fields: values are arbitrary
`define TAP_ID_VERSION    4'h3
`define TAP_ID_PART       16'h5A5A
`define TAP_ID_MAKER      11'h2A5
`define TAP_ID_LSB        1'h1
`define TAP_USER_BITS     7
`define TAP_USER_FIXED    25'h0C0FFEE

`endif

// ### hdl/tap_pkg.sv
// types shared by the boundary-scan test access port
package tap_pkg;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } tap_state_t;

    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_EXTEST, SEL_SAMPLE, SEL_IDCODE, SEL_USERCODE,
        SEL_CFG_LOAD, SEL_CFG_START
    } dr_sel_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe_n;
    } tap_out_t;

    typedef struct packed {
        logic bit_valid;
        logic bit_value;
        logic start;
    } cfg_stream_t;

endpackage : tap_pkg

// ### hdl/jtag_boundary_scan_tap.sv
// boundary-scan test access port with boundary chain and pin muxing
`timescale 1ns/1ps
`include "tap_params.svh"

module jtag_boundary_scan_tap
    import tap_pkg::*;
#(
    parameter int                    BSR_LEN      = `TAP_BSR_LEN_DEF,
    parameter logic [BSR_LEN-1:0]    OD_MASK      = '0,
    parameter logic [`TAP_IR_LEN-1:0] OP_EXTEST    = `TAP_OP_EXTEST,
    parameter logic [`TAP_IR_LEN-1:0] OP_SAMPLE    = `TAP_OP_SAMPLE,
    parameter logic [`TAP_IR_LEN-1:0] OP_IDCODE    = `TAP_OP_IDCODE,
    parameter logic [`TAP_IR_LEN-1:0] OP_USERCODE  = `TAP_OP_USERCODE,
    parameter logic [`TAP_IR_LEN-1:0] OP_CFG_LOAD  = `TAP_OP_CFG_LOAD,
    parameter logic [`TAP_IR_LEN-1:0] OP_CFG_START = `TAP_OP_CFG_START
) (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire tap_in_t               jtag_in,
    output tap_out_t                   jtag_out,
    input  wire logic                  config_busy,
    input  wire logic                  dev_ready,
    input  wire logic [`TAP_USER_BITS-1:0] user_sig,
    input  wire logic [BSR_LEN-1:0]    pin_in,
    input  wire logic [BSR_LEN-1:0]    core_out,
    input  wire logic [BSR_LEN-1:0]    core_oe_n,
    output logic [BSR_LEN-1:0]         pin_out,
    output logic [BSR_LEN-1:0]         pin_oe_n,
    output cfg_stream_t                cfg_stream
);

    localparam int IRL = `TAP_IR_LEN;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // [RQ11] chain length limited to device sizes
    if (BSR_LEN != 690 && BSR_LEN != 798 && BSR_LEN != 1050 &&
        BSR_LEN != 1308 && BSR_LEN != 1446) begin : g_bad_len
        $error("boundary chain length not supported");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    tap_in_t              jin_s1_r, jin_s2_r;
    logic                 tck_d_r;
    logic [1:0]           busy_s_r, ready_s_r;
    logic [BSR_LEN-1:0]   pin_s1_r, pin_s2_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            jin_s1_r  <= '0;
            jin_s2_r  <= '0;
            tck_d_r   <= 1'b0;
            busy_s_r  <= 2'h0;
            ready_s_r <= 2'h0;
            pin_s1_r  <= '0;
            pin_s2_r  <= '0;
        end else begin
            jin_s1_r  <= jtag_in;
            jin_s2_r  <= jin_s1_r;
            tck_d_r   <= jin_s2_r.tck;
            busy_s_r  <= {busy_s_r[0], config_busy};
            ready_s_r <= {ready_s_r[0], dev_ready};
            pin_s1_r  <= pin_in;
            pin_s2_r  <= pin_s1_r;
        end
    end

    wire tck_rise = jin_s2_r.tck & ~tck_d_r;
    wire tck_fall = ~jin_s2_r.tck & tck_d_r;
    wire tms      = jin_s2_r.tms;
    wire tdi      = jin_s2_r.tdi;
    wire busy     = busy_s_r[1];
    wire ready    = ready_s_r[1];

    // ------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------
    function automatic tap_state_t next_state(input tap_state_t s, input logic m);
        case (s)
            ST_RESET:  return m ? ST_RESET  : ST_IDLE;
            ST_IDLE:   return m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: return m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  return m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: return m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  return m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: return m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: return m ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: return m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  return m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: return m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  return m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: return m ? ST_SEL_DR : ST_IDLE;
            default:   return ST_RESET;
        endcase
    endfunction : next_state

    tap_state_t state_r, state_nxt;
    // [RQ1] standard controller stepped on each test clock rise
    assign state_nxt = tck_rise ? next_state(state_r, tms) : state_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) state_r <= ST_RESET;
        else       state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    logic [IRL-1:0] ir_r, ir_sh_r;

    // [RQ15] unknown opcodes fall through to bypass
    function automatic dr_sel_t decode(input logic [IRL-1:0] ir, input logic cfg);
        // [RQ2] boundary access refused during configuration
        if (ir == OP_EXTEST && !cfg)      return SEL_EXTEST;
        else if (ir == OP_SAMPLE && !cfg) return SEL_SAMPLE;
        else if (ir == OP_IDCODE)         return SEL_IDCODE;
        else if (ir == OP_USERCODE)       return SEL_USERCODE;
        else if (ir == OP_CFG_LOAD)       return SEL_CFG_LOAD;
        else if (ir == OP_CFG_START)      return SEL_CFG_START;
        else                              return SEL_BYPASS;
    endfunction : decode

    dr_sel_t sel;
    assign sel = decode(ir_r, busy);

    wire sel_bsr  = (sel == SEL_EXTEST) || (sel == SEL_SAMPLE);
    wire sel_w32  = (sel == SEL_IDCODE) || (sel == SEL_USERCODE);
    wire rise_cdr = tck_rise && state_r == ST_CAP_DR;
    wire rise_sdr = tck_rise && state_r == ST_SH_DR;
    wire fall_udr = tck_fall && state_r == ST_UPD_DR;

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [IRL-1:0] ir_sh_nxt, ir_nxt;
    // [RQ3] ten-bit capture and shift path
    assign ir_sh_nxt = (tck_rise && state_r == ST_CAP_IR) ? `TAP_IR_CAPTURE :
                       (tck_rise && state_r == ST_SH_IR)  ? {tdi, ir_sh_r[IRL-1:1]} :
                       ir_sh_r;
    // [RQ16] reset state reloads identification
    assign ir_nxt = (state_r == ST_RESET)                 ? OP_IDCODE :
                    (tck_fall && state_r == ST_UPD_IR)    ? ir_sh_r :
                    ir_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ir_r    <= OP_IDCODE;
            ir_sh_r <= '0;
        end else begin
            ir_r    <= ir_nxt;
            ir_sh_r <= ir_sh_nxt;
        end
    end

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    // [RQ9] identification word layout, lsb fixed at one
    // [RQ10] constant one sits in bit 0, first out
    wire [31:0] id_word   = {`TAP_ID_VERSION, `TAP_ID_PART, `TAP_ID_MAKER, `TAP_ID_LSB};
    // [RQ7] 25 fixed bits above 7 user bits
    wire [31:0] user_word = {`TAP_USER_FIXED, user_sig};

    logic                byp_r, byp_nxt;
    logic [31:0]         w32_r, w32_nxt;
    logic [BSR_LEN-1:0]  bsr_r, bsr_nxt, upd_r, upd_nxt;

    // [RQ6] one-bit bypass stage, captures zero
    assign byp_nxt = rise_cdr ? 1'b0 : rise_sdr ? tdi : byp_r;
    // [RQ8] identification or signature loaded on capture
    assign w32_nxt = (rise_cdr && sel_w32) ?
                         ((sel == SEL_IDCODE) ? id_word : user_word) :
                     (rise_sdr && sel_w32) ? {tdi, w32_r[31:1]} : w32_r;
    // [RQ4] pin snapshot then serial preload of the chain
    assign bsr_nxt = (rise_cdr && sel_bsr) ? pin_s2_r :
                     (rise_sdr && sel_bsr) ? {tdi, bsr_r[BSR_LEN-1:1]} : bsr_r;
    assign upd_nxt = (fall_udr && sel_bsr) ? bsr_r : upd_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            byp_r <= 1'b0;
            w32_r <= '0;
            bsr_r <= '0;
            upd_r <= '0;
        end else begin
            byp_r <= byp_nxt;
            w32_r <= w32_nxt;
            bsr_r <= bsr_nxt;
            upd_r <= upd_nxt;
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    wire shifting = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
    wire dr_bit   = sel_bsr ? bsr_r[0] : sel_w32 ? w32_r[0] : byp_r;
    wire ser_bit  = (state_r == ST_SH_IR) ? ir_sh_r[0] : dr_bit;
    tap_out_t out_r, out_nxt;

    // [RQ16] serial out driven only in shift states, on falling edge
    assign out_nxt = tck_fall ? tap_out_t'{tdo: ser_bit, tdo_oe_n: ~shifting} : out_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) out_r <= '{tdo: 1'b1, tdo_oe_n: 1'b1};
        else       out_r <= out_nxt;
    end
    assign jtag_out = out_r;

    // ------------------------------------------------------------
    // configuration stream
    // ------------------------------------------------------------
    cfg_stream_t cfg_r, cfg_nxt;
    // [RQ12] configuration bits passed on as they shift in
    assign cfg_nxt = '{bit_valid: rise_sdr && sel == SEL_CFG_LOAD,
                       bit_value: tdi,
                       start:     fall_udr && sel == SEL_CFG_START};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) cfg_r <= '0;
        else       cfg_r <= cfg_nxt;
    end
    assign cfg_stream = cfg_r;

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // [RQ5] extest hands the pins to the update stage
    wire extest = (sel == SEL_EXTEST);
    logic [BSR_LEN-1:0] pout_r, poe_n_r;
    wire  [BSR_LEN-1:0] pout_nxt, poe_n_nxt;

    for (genvar i = 0; i < BSR_LEN; i++) begin : g_pin
        wire val = extest ? upd_r[i] : core_out[i];
        wire en_n = extest ? 1'b0 : core_oe_n[i];
        // [RQ13] open-drain cell releases instead of driving high
        assign pout_nxt[i]  = OD_MASK[i] ? 1'b0 : val;
        // [RQ14] everything released until ready
        assign poe_n_nxt[i] = ~ready | (OD_MASK[i] ? (val | en_n) : en_n);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pout_r  <= '0;
            poe_n_r <= '1;
        end else begin
            pout_r  <= pout_nxt;
            poe_n_r <= poe_n_nxt;
        end
    end
    assign pin_out  = pout_r;
    assign pin_oe_n = poe_n_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [2:0] ones_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn)         ones_r <= 3'h0;
        else if (tck_rise) ones_r <= !tms ? 3'h0 : (ones_r == 3'h5) ? ones_r : ones_r + 3'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence cap_dr_s(dr_sel_t s);
        tck_rise && state_r == ST_CAP_DR && sel == s;
    endsequence
    sequence cap_ir_s;
        tck_rise && state_r == ST_CAP_IR;
    endsequence

    tms_reset_a: assert property (ones_r == 3'h5 |-> state_r == ST_RESET) // [RQ1]
        else $error("five tms highs did not reach reset");
    busy_blocks_a: assert property (busy |-> !sel_bsr) // [RQ2]
        else $error("boundary selected during configuration");
    ir_capture_a: assert property (cap_ir_s |=> ir_sh_r == `TAP_IR_CAPTURE) // [RQ3]
        else $error("instruction capture value wrong");
    sample_cap_a: assert property (cap_dr_s(SEL_SAMPLE) |=> bsr_r == $past(pin_s2_r)) // [RQ4]
        else $error("pin snapshot not captured");
    extest_drive_a: assert property ((extest && ready) ##1 1 |-> // [RQ5]
        (pout_r & ~OD_MASK) == ($past(upd_r) & ~OD_MASK))
        else $error("pins not driven from update stage");
    bypass_cap_a: assert property (cap_dr_s(SEL_BYPASS) |=> !byp_r) // [RQ6]
        else $error("bypass did not capture zero");
    user_fixed_a: assert property (cap_dr_s(SEL_USERCODE) |=> // [RQ7]
        w32_r[31:`TAP_USER_BITS] == `TAP_USER_FIXED)
        else $error("signature fixed bits wrong");
    id_capture_a: assert property (cap_dr_s(SEL_IDCODE) |=> w32_r == id_word) // [RQ8]
        else $error("identification word not loaded");
    id_lsb_a: assert property (cap_dr_s(SEL_IDCODE) |=> w32_r[0]) // [RQ10]
        else $error("identification lsb not one");
    od_high_a: assert property (((~pin_oe_n) & pin_out & OD_MASK) == '0) // [RQ13]
        else $error("open-drain pin driven high");
    power_up_a: assert property (!ready ##1 1 |-> &pin_oe_n) // [RQ14]
        else $error("pin driven before ready");
    ir_reset_a: assert property (state_r == ST_RESET |=> ir_r == OP_IDCODE) // [RQ16]
        else $error("reset did not load identification");
    tdo_hiz_a: assert property (tck_fall && !shifting |=> jtag_out.tdo_oe_n) // [RQ16]
        else $error("serial out driven outside shift");
    cfg_bit_a: assert property (tck_rise && state_r == ST_SH_DR && // [RQ12]
        sel == SEL_CFG_LOAD |=> cfg_stream.bit_valid && cfg_stream.bit_value == $past(tdi))
        else $error("configuration bit not forwarded");

endmodule : jtag_boundary_scan_tap

// ### tb/tap_tester.sv
// board tester model driving the four-wire test port
`timescale 1ns/1ps

module tap_tester
    import tap_pkg::*;
(
    input  wire logic     core_clk,
    input  wire tap_out_t jtag_out,
    output tap_in_t       jtag_in
);
    int oe_cnt;

    initial jtag_in = 3'b011;

    // one tck period of 16 core cycles; tck stands low between frames
    // tester side of controller
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge core_clk);
        jtag_in.tms <= tms;
        jtag_in.tdi <= tdi;
        repeat (7) @(posedge core_clk);
        jtag_in.tck <= 1'b1;
        tdo = jtag_out.tdo;
        oe_cnt += int'(jtag_out.tdo_oe_n === 1'b0);
        repeat (8) @(posedge core_clk);
        jtag_in.tck <= 1'b0;
        // released tdi floats to the pull-up level
        jtag_in.tdi <= 1'b1;
    endtask : step

    task automatic go(input logic [7:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) step(seq[i], 1'b1, d);
    endtask : go

    // five tms-high rises reach test-logic-reset, one low lands in idle
    task automatic reset_tap();
        go(8'h1F, 6);
    endtask : reset_tap

    task automatic scan(input logic ir, input int n, input logic [1023:0] din,
                        output logic [1023:0] dout);
        logic d;
        dout = '0;
        oe_cnt = 0;
        if (ir) go(8'h03, 4);
        else go(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        go(8'h01, 2);
    endtask : scan
endmodule : tap_tester

// ### tb/jtag_boundary_scan_tap_test.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "tap_params.svh"

module jtag_boundary_scan_tap_test
    import tap_pkg::*;
;
    localparam int N = 690;
    localparam logic [N-1:0] PAT_A = {230{3'b110}};
    localparam logic [N-1:0] PAT_B = {345{2'b01}};
    localparam logic [N-1:0] PAT_C = {138{5'b10011}};

    logic          core_clk = 1'b0;
    logic          rstn = 1'b0;
    tap_in_t       jtag_in;
    tap_out_t      jtag_out;
    logic          config_busy = 1'b0;
    logic          dev_ready = 1'b0;
    logic [6:0]    user_sig = 7'h5A;
    logic [N-1:0]  pin_in = PAT_A;
    logic [N-1:0]  core_out = PAT_C;
    logic [N-1:0]  core_oe_n = '0;
    logic [N-1:0]  pin_out;
    logic [N-1:0]  pin_oe_n;
    cfg_stream_t   cfg_stream;
    logic [1023:0] o;
    logic [7:0]    cfg_bits = '0;
    int            cfg_n = 0;
    int            starts = 0;
    int            num_errors = 0;
    int            n_tests = 0;
    int            cyc = 0;

    always #2.5 core_clk = ~core_clk;

    jtag_boundary_scan_tap #(.BSR_LEN(N), .OD_MASK(690'h1)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .jtag_in(jtag_in), .jtag_out(jtag_out),
        .config_busy(config_busy), .dev_ready(dev_ready), .user_sig(user_sig),
        .pin_in(pin_in), .core_out(core_out), .core_oe_n(core_oe_n),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cfg_stream(cfg_stream));

    tap_tester tst (.core_clk(core_clk), .jtag_out(jtag_out), .jtag_in(jtag_in));

    // -------------------------------------------------------------
    // monitors, checking and closing
    // -------------------------------------------------------------
    always @(posedge core_clk) begin
        if (cfg_stream.bit_valid === 1'b1) begin
            cfg_bits <= {cfg_stream.bit_value, cfg_bits[7:1]};
            cfg_n <= cfg_n + 1;
        end
        if (cfg_stream.start === 1'b1) starts <= starts + 1;
        cyc <= cyc + 1;
        // the full run needs about 28000 cycles
        if (cyc == 80000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input logic [1023:0] seen, input logic [1023:0] exp,
                         input string msg);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic load_ir(input logic [9:0] op);
        tst.scan(1'b1, 10, 1024'(op), o);
        check(o[9:0], 10'h001, "instruction capture");
        check(tst.oe_cnt, 10, "tdo enabled per ir bit");
    endtask : load_ir

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_ready();
        check(pin_oe_n, {N{1'b1}}, "pins driven before ready");
        @(posedge core_clk) dev_ready <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(pin_oe_n, {core_oe_n[N-1:1], 1'b1}, "open drain released");
        check(pin_out, {core_out[N-1:1], 1'b0}, "open drain drove high");
        @(posedge core_clk) core_out[0] <= 1'b0;
        repeat (4) @(posedge core_clk);
        check({pin_out[0], pin_oe_n[0]}, 2'b00, "open drain low");
        @(posedge core_clk) core_out[0] <= 1'b1;
        $display("test ready done");
    endtask : t_ready

    task automatic t_idcode();
        tst.reset_tap();
        tst.scan(1'b0, 32, '0, o);
        check(o[31:0], {`TAP_ID_VERSION, `TAP_ID_PART, `TAP_ID_MAKER, `TAP_ID_LSB},
              "id word");
        check(o[0], 1'b1, "id first bit");
        check(tst.oe_cnt, 32, "tdo enable in shift");
        check(jtag_out.tdo_oe_n, 1'b1, "tdo driven in idle");
        $display("test idcode done");
    endtask : t_idcode

    task automatic t_bypass();
        for (int i = 0; i < 2; i++) begin
            load_ir(i == 0 ? 10'h3FF : 10'h155);
            tst.scan(1'b0, 3, 1024'(3'b101), o);
            check(o[2:0], 3'b010, "one stage bypass");
        end
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_user();
        load_ir(`TAP_OP_USERCODE);
        tst.scan(1'b0, 32, '0, o);
        check(o[31:0], {`TAP_USER_FIXED, user_sig}, "signature word");
        $display("test user done");
    endtask : t_user

    task automatic t_boundary();
        load_ir(`TAP_OP_SAMPLE);
        tst.scan(1'b0, N, 1024'(PAT_B), o);
        check(o[N-1:0], PAT_A, "sample capture");
        check(pin_out[N-1:1], core_out[N-1:1], "sample disturbed pins");
        load_ir(`TAP_OP_EXTEST);
        repeat (4) @(posedge core_clk);
        check(pin_out[N-1:1], PAT_B[N-1:1], "preload not driven");
        check(pin_oe_n[N-1:1], '0, "extest enables");
        @(posedge core_clk) pin_in <= PAT_C;
        tst.scan(1'b0, N, 1024'(PAT_A), o);
        check(o[N-1:0], PAT_C, "extest capture");
        check(pin_out[N-1:1], PAT_A[N-1:1], "extest update");
        tst.reset_tap();
        repeat (4) @(posedge core_clk);
        check(pin_out[N-1:1], core_out[N-1:1], "pins back to core");
        $display("test boundary done");
    endtask : t_boundary

    task automatic t_busy();
        @(posedge core_clk) config_busy <= 1'b1;
        load_ir(`TAP_OP_EXTEST);
        tst.scan(1'b0, 2, 1024'(2'b01), o);
        check(o[1:0], 2'b10, "boundary while busy");
        check(pin_out[N-1:1], core_out[N-1:1], "pins taken while busy");
        @(posedge core_clk) config_busy <= 1'b0;
        tst.reset_tap();
        $display("test busy done");
    endtask : t_busy

    task automatic t_cfg();
        load_ir(`TAP_OP_CFG_LOAD);
        @(posedge core_clk) cfg_n <= 0;
        tst.scan(1'b0, 8, 1024'(8'hB4), o);
        check(cfg_n, 8, "config bit count");
        check(cfg_bits, 8'hB4, "config bit order");
        load_ir(`TAP_OP_CFG_START);
        tst.scan(1'b0, 1, '0, o);
        check(starts, 1, "config start pulse");
        $display("test cfg done");
    endtask : t_cfg

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_ready();
        t_idcode();
        t_bypass();
        t_user();
        t_boundary();
        t_busy();
        t_cfg();
        t_idcode();
        test_done();
    end
endmodule : jtag_boundary_scan_tap_test
